// File: rtl/acsfm_params.svh
`ifndef ACSFM_PARAMS_SVH
`define ACSFM_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define ACSFM_CLK_MHZ        125
`define ACSFM_MAINS_PERIOD_US 20000
`define ACSFM_PERIOD_CYC     ((`ACSFM_MAINS_PERIOD_US) * (`ACSFM_CLK_MHZ))
`define ACSFM_CNT_W          32
`define ACSFM_CONFIRM_N      3
`define ACSFM_CONFIRM_W      3

// ****************************************************************
// Mode codes
// ****************************************************************
`define ACSFM_MODE_OFF       2'h0
`define ACSFM_MODE_LEVEL     2'h1
`define ACSFM_MODE_PULSE     2'h2
`define ACSFM_MODE_PHASE     2'h3

`endif

// File: rtl/acsfm_pkg.sv
package acsfm_pkg;
    typedef enum logic [2:0] {
        ACSFM_ST_OK       = 3'h0,
        ACSFM_ST_DIODE    = 3'h1,
        ACSFM_ST_SHORT    = 3'h2,
        ACSFM_ST_OPEN     = 3'h3,
        ACSFM_ST_UNKNOWN  = 3'h4
    } acsfm_status_t;
endpackage

// File: rtl/acsfm_sync.sv
`timescale 1ns/10ps
// ****************************************************************
// Three-stage input synchroniser with agreement filter
// ****************************************************************
module acsfm_sync (
    input  wire logic clk,      // Clock
    input  wire logic resetn,   // Async reset, low
    input  wire logic ce,       // Clock enable
    input  wire logic din,      // Asynchronous pin
    output logic      dout      // Filtered level
);
    logic s1, s2, s3;
    logic next_dout;

    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s3;
        end
    end

    // Reset high: a released line idles high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1   <= 1'b1;
            s2   <= 1'b1;
            s3   <= 1'b1;
            dout <= 1'b1;
        end else if (ce) begin
            s1   <= din;
            s2   <= s1;
            s3   <= s2;
            dout <= next_dout;
        end
    end
endmodule // acsfm_sync

// File: rtl/acsfm_ctrl.sv
`timescale 1ns/10ps
`include "acsfm_params.svh"
module acsfm_ctrl #(
    parameter int unsigned PERIOD_CYC = `ACSFM_PERIOD_CYC // Mains period in clocks
) (
    input  wire logic                  clk,          // Clock 125 MHz
    input  wire logic                  resetn,       // Async reset, low
    input  wire logic                  ce,           // Clock enable
    input  wire logic                  switch_req,   // Request switch on
    input  wire logic [1:0]            drive_mode,   // Drive mode code
    input  wire logic                  fire_pulse,   // Pulse / phase fire strobe
    input  wire logic                  peak_strobe,  // Mains peak instant
    input  wire logic                  fault_clear,  // Clear latched fault
    input  wire logic                  alt_voltage_feedback, // Feedback pin
    output logic                       feedback_pu,  // Pull-up enable
    output logic                       drive_out,    // Switch drive pin
    output logic                       relay_on,     // Front-end relay
    output logic                       fault,        // Latched fault
    output acsfm_pkg::acsfm_status_t   status        // Confirmed class
);
    import acsfm_pkg::*;

    // ****************************************************************
    // Input capture and drive
    // ****************************************************************
    logic fb;
    logic drive_bit;
    logic next_drive_bit;

    acsfm_sync u_sync (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .din    (alt_voltage_feedback),
        .dout   (fb)
    );

    assign feedback_pu = 1'b1;

    always_comb begin
        next_drive_bit = 1'b0;
        if (relay_on && switch_req) begin
            unique case (drive_mode)
                `ACSFM_MODE_OFF:   next_drive_bit = 1'b0;
                `ACSFM_MODE_LEVEL: next_drive_bit = 1'b1;
                `ACSFM_MODE_PULSE: next_drive_bit = fire_pulse;
                `ACSFM_MODE_PHASE: next_drive_bit = fire_pulse;
            endcase
        end
    end

    // Drive pin and stored bit are the same flop
    assign drive_out = drive_bit;

    // ****************************************************************
    // Window observation over one mains period
    // ****************************************************************
    logic [`ACSFM_CNT_W-1:0] cnt, next_cnt;
    logic seen_low, seen_high, drv_on, drv_off;
    logic next_seen_low, next_seen_high, next_drv_on, next_drv_off;
    logic win_end;
    acsfm_status_t win_class, cand, next_cand;
    logic [`ACSFM_CONFIRM_W-1:0] rep, next_rep;
    acsfm_status_t next_status;
    logic next_fault, next_relay_on;

    assign win_end = (cnt == `ACSFM_CNT_W'(PERIOD_CYC - 1));

    always_comb begin
        next_cnt       = win_end ? '0 : cnt + `ACSFM_CNT_W'(1);
        next_seen_low  = win_end ? 1'b0 : seen_low;
        next_seen_high = win_end ? 1'b0 : seen_high;
        next_drv_on    = win_end ? 1'b0 : drv_on;
        next_drv_off   = win_end ? 1'b0 : drv_off;
        // Sample at peak only so inductive lag is covered
        if (peak_strobe && !win_end) begin
            next_seen_low  = seen_low | ~fb;
            next_seen_high = seen_high | fb;
            next_drv_on    = drv_on | drive_bit;
            next_drv_off   = drv_off | ~drive_bit;
        end
    end

    always_comb begin
        win_class = ACSFM_ST_UNKNOWN;
        if (drv_off && !drv_on) begin
            if (seen_low && seen_high) begin
                win_class = ACSFM_ST_DIODE;
            end else if (seen_low) begin
                win_class = ACSFM_ST_SHORT;
            end else if (seen_high) begin
                win_class = ACSFM_ST_OK;
            end
        end else if (drv_on && !drv_off) begin
            if (seen_high) begin
                win_class = ACSFM_ST_OPEN;
            end else if (seen_low) begin
                win_class = ACSFM_ST_OK;
            end
        end
    end

    // ****************************************************************
    // Confirmation and safe state
    // ****************************************************************
    always_comb begin
        next_cand     = cand;
        next_rep      = rep;
        next_status   = status;
        next_fault    = fault;
        next_relay_on = relay_on;
        if (win_end && win_class != ACSFM_ST_UNKNOWN) begin
            if (win_class == cand) begin
                if (rep != `ACSFM_CONFIRM_W'(`ACSFM_CONFIRM_N)) begin
                    next_rep = rep + `ACSFM_CONFIRM_W'(1);
                end
            end else begin
                next_cand = win_class;
                next_rep  = `ACSFM_CONFIRM_W'(1);
            end
        end
        if (next_rep == `ACSFM_CONFIRM_W'(`ACSFM_CONFIRM_N)) begin
            next_status = next_cand;
        end
        if (fault_clear) begin
            next_fault    = 1'b0;
            next_relay_on = 1'b1;
        end
        // Set beats clear
        if (next_status != ACSFM_ST_OK && next_status != ACSFM_ST_UNKNOWN) begin
            next_fault    = 1'b1;
            next_relay_on = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drive_bit <= 1'b0;
            cnt       <= '0;
            seen_low  <= 1'b0;
            seen_high <= 1'b0;
            drv_on    <= 1'b0;
            drv_off   <= 1'b0;
            cand      <= ACSFM_ST_UNKNOWN;
            rep       <= '0;
            status    <= ACSFM_ST_UNKNOWN;
            fault     <= 1'b0;
            relay_on  <= 1'b1;
        end else if (ce) begin
            drive_bit <= next_drive_bit;
            cnt       <= next_cnt;
            seen_low  <= next_seen_low;
            seen_high <= next_seen_high;
            drv_on    <= next_drv_on;
            drv_off   <= next_drv_off;
            cand      <= next_cand;
            rep       <= next_rep;
            status    <= next_status;
            fault     <= next_fault;
            relay_on  <= next_relay_on;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_RELAY_DROP: assert property (@(posedge clk) disable iff (!resetn)
        fault |-> !relay_on)
        else $error("relay on while fault");
    AST_NO_DRIVE_RELAY_OFF: assert property (@(posedge clk) disable iff (!resetn)
        (ce && !relay_on) |=> !drive_out)
        else $error("drive with relay off");
    AST_LEVEL_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
        (ce && relay_on && switch_req && drive_mode == `ACSFM_MODE_LEVEL) |=> drive_out)
        else $error("level mode not driving");
    AST_PULSE_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
        (ce && drive_mode == `ACSFM_MODE_PULSE && !fire_pulse) |=> !drive_out)
        else $error("pulse without fire");
    AST_PHASE_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
        (ce && relay_on && switch_req && drive_mode == `ACSFM_MODE_PHASE) |=> drive_out == $past(fire_pulse))
        else $error("phase drive not following fire");
    AST_OFF_MODE: assert property (@(posedge clk) disable iff (!resetn)
        (ce && drive_mode == `ACSFM_MODE_OFF) |=> !drive_out)
        else $error("drive in off mode");
    AST_NO_REQ: assert property (@(posedge clk) disable iff (!resetn)
        (ce && !switch_req) |=> !drive_out)
        else $error("drive without request");
    AST_PU: assert property (@(posedge clk) disable iff (!resetn)
        feedback_pu)
        else $error("pull-up off");
    AST_STATUS_CONF: assert property (@(posedge clk) disable iff (!resetn)
        (ce && status != $past(status)) |-> rep == `ACSFM_CONFIRM_W'(`ACSFM_CONFIRM_N))
        else $error("status unconfirmed");
    // Status may only move at a window end
    AST_STATUS_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        (!ce || !win_end) |=> $stable(status))
        else $error("status moved inside window");
    AST_WIN_RESET: assert property (@(posedge clk) disable iff (!resetn)
        (ce && win_end) |=> (cnt == '0 && !seen_low && !seen_high))
        else $error("window not reset");
    AST_FAULT_SET: assert property (@(posedge clk) disable iff (!resetn)
        (status == ACSFM_ST_SHORT || status == ACSFM_ST_DIODE || status == ACSFM_ST_OPEN) |-> fault)
        else $error("fault missing");
    // Set beats clear while the failing class stands
    AST_CLEAR_KEEP: assert property (@(posedge clk) disable iff (!resetn)
        (ce && fault_clear && !win_end &&
         (status == ACSFM_ST_SHORT || status == ACSFM_ST_DIODE || status == ACSFM_ST_OPEN)) |=> fault)
        else $error("clear beat a standing fault");
    AST_CLEAR_RELAY: assert property (@(posedge clk) disable iff (!resetn)
        (ce && fault_clear && !win_end && (status == ACSFM_ST_OK || status == ACSFM_ST_UNKNOWN))
        |=> (relay_on && !fault))
        else $error("clear did not restore relay");
    AST_FREEZE: assert property (@(posedge clk) disable iff (!resetn)
        !ce |=> $stable(cnt))
        else $error("state moved without enable");
endmodule // acsfm_ctrl

// File: dv/acsfm_dev_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Behavioural switch driver and feedback detector
// ****************************************************************
module acsfm_dev_model #(
    parameter int HALF = 40
) (
    input  wire logic       clk,       // Bench clock, mains timing only
    input  wire logic       drive_in,  // Switch drive pin
    input  wire logic [1:0] fail_mode, // 0 ok, 1 diode, 2 short, 3 open
    output wire logic       peak,      // Mains peak instant
    inout  wire             fb_pin     // Open-collector feedback
);
    int   ph   = 0;
    logic pos  = 1'b1;
    logic cond = 1'b0;
    wire  pull;
    always @(posedge clk) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) pos <= ~pos;
        if (fail_mode == 2'h3) cond <= 1'b0;
        else if (drive_in || fail_mode == 2'h2) cond <= 1'b1;
        else if (ph == HALF - 1) cond <= 1'b0;
    end
    assign peak = (ph == HALF / 2);
    // Diode conducts in one polarity only, hence one pulse per full mains cycle
    assign pull = cond || (fail_mode == 2'h1 && pos);
    assign fb_pin = pull ? 1'b0 : 1'bz;
endmodule // acsfm_dev_model

// File: dv/ac_switch_fault_monitor_test.sv
`timescale 1ns/10ps
`include "acsfm_params.svh"
module ac_switch_fault_monitor_test;
    import acsfm_pkg::*;
    logic            clk = 1'b0;
    logic            resetn = 1'b0;
    logic            ce = 1'b1;
    logic            switch_req = 1'b0;
    logic [1:0]      drive_mode = 2'h0;
    logic            fire_pulse = 1'b0;
    logic            fault_clear = 1'b0;
    logic [1:0]      fail_mode = 2'h0;
    logic            peak;
    tri1             fb;
    logic            feedback_pu, drive_out, relay_on, fault;
    acsfm_status_t   status;
    int              errors = 0;
    int              check_count = 0;
    int              cycles = 0;
    logic            exp_d, next_exp;
    int unsigned     junk;
    logic            peak_en = 1'b0;
    logic            peak_gate;
    localparam int   HALF = 40;

    initial forever #4 clk = ~clk;

    // Peaks held off in random runs: a short window with steady drive would latch a fault
    assign peak_gate = peak & peak_en;

    acsfm_ctrl #(.PERIOD_CYC(2 * HALF)) acsfm_ctrl_i (.clk(clk), .resetn(resetn), .ce(ce),
        .switch_req(switch_req), .drive_mode(drive_mode), .fire_pulse(fire_pulse), .peak_strobe(peak_gate),
        .fault_clear(fault_clear), .alt_voltage_feedback(fb), .feedback_pu(feedback_pu),
        .drive_out(drive_out), .relay_on(relay_on), .fault(fault), .status(status));
    acsfm_dev_model #(.HALF(HALF)) acsfm_dev_model_i (.clk(clk), .drive_in(drive_out), .fail_mode(fail_mode),
        .peak(peak), .fb_pin(fb));

    function automatic logic exp_drive(logic [1:0] m, logic rq, logic fp);
        case (m)
            2'h0:    return 1'b0;
            2'h1:    return rq;
            default: return fp;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string msg);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic close_out;
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Hang guard, well above the few thousand cycles needed
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out;
        end
    end

    task automatic settle_checks;
        check({7'h0, feedback_pu}, 8'h01, "pull-up enable");
        check({7'h0, relay_on}, 8'h01, "relay dropped");
        check({7'h0, fault}, 8'h00, "early fault");
        check({5'h0, status}, {5'h0, ACSFM_ST_UNKNOWN}, "early status");
    endtask

    task automatic run_random(input int n);
        for (int i = 0; i < n; i++) begin
            next_exp = ce ? exp_drive(drive_mode, switch_req, fire_pulse) : exp_d;
            @(posedge clk);
            #1;
            check({7'h0, drive_out}, {7'h0, next_exp}, "drive level");
            settle_checks;
            exp_d = next_exp;
            if (i % 200 == 0) fail_mode = 2'($urandom_range(3));
            drive_mode  = 2'($urandom_range(3));
            // Pulse and phase modes need the request held, fire gates them
            switch_req  = drive_mode[1] ? 1'b1 : 1'($urandom_range(1));
            fire_pulse  = 1'($urandom_range(1));
            ce          = ($urandom_range(7) != 0);
            fault_clear = ($urandom_range(31) == 0);
        end
    endtask

    // ****************************************************************
    // Classification, reset released so no peak hits a window end
    // ****************************************************************
    task automatic classify(input logic [1:0] m, input logic [1:0] fm, input acsfm_status_t want);
        resetn      = 1'b0;
        ce          = 1'b1;
        fire_pulse  = 1'b0;
        fault_clear = 1'b0;
        peak_en     = 1'b1;
        drive_mode  = m;
        switch_req  = 1'b1;
        fail_mode   = fm;
        @(posedge clk);
        #1;
        while (!peak) begin
            @(posedge clk);
            #1;
        end
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (200) @(posedge clk);
        #1;
        check({5'h0, status}, {5'h0, ACSFM_ST_UNKNOWN}, "status before confirm");
        repeat (41) @(posedge clk);
        #1;
        check({5'h0, status}, {5'h0, want}, "window class");
        check({7'h0, fault}, {7'h0, want != ACSFM_ST_OK}, "fault flag");
        check({7'h0, relay_on}, {7'h0, want == ACSFM_ST_OK}, "relay state");
    endtask

    initial begin
        junk = $urandom(32'h91022188);
        repeat (2) @(posedge clk);
        #1;
        settle_checks;
        check({7'h0, drive_out}, 8'h00, "drive in reset");
        resetn = 1'b1;
        exp_d  = 1'b0;
        // Corner: level on, then ce frozen with request dropped
        drive_mode = 2'h1;
        switch_req = 1'b1;
        run_random(1);
        ce         = 1'b0;
        switch_req = 1'b0;
        run_random(1);
        run_random(1500);
        // Mid-run reset must drop drive at once
        drive_mode = 2'h1;
        switch_req = 1'b1;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b0;
        #1;
        check({7'h0, drive_out}, 8'h00, "drive after reset");
        @(posedge clk);
        #1;
        resetn = 1'b1;
        exp_d  = 1'b0;
        drive_mode = 2'h0;
        run_random(1500);
        classify(`ACSFM_MODE_OFF, 2'h0, ACSFM_ST_OK);
        classify(`ACSFM_MODE_LEVEL, 2'h0, ACSFM_ST_OK);
        classify(`ACSFM_MODE_OFF, 2'h1, ACSFM_ST_DIODE);
        classify(`ACSFM_MODE_LEVEL, 2'h3, ACSFM_ST_OPEN);
        classify(`ACSFM_MODE_OFF, 2'h2, ACSFM_ST_SHORT);
        // Set beats clear while the short persists
        fault_clear = 1'b1;
        @(posedge clk);
        #1;
        fault_clear = 1'b0;
        check({7'h0, fault}, 8'h01, "clear lost to set");
        fail_mode = 2'h0;
        repeat (400) @(posedge clk);
        #1;
        check({5'h0, status}, {5'h0, ACSFM_ST_OK}, "recovered class");
        check({7'h0, fault}, 8'h01, "fault not latched");
        fault_clear = 1'b1;
        @(posedge clk);
        #1;
        fault_clear = 1'b0;
        check({7'h0, fault}, 8'h00, "fault not cleared");
        check({7'h0, relay_on}, 8'h01, "relay not restored");
        close_out;
    end
endmodule // ac_switch_fault_monitor_test
